// File: core/vpa_path.v
// Plane mask, write bit mask and attribute colour path with the
// indexed host registers and the external video DAC strobes.
// Assumes host I/O strobes and pixel inputs are synchronous to
// core_clk_in; palette lookup sits outside between plane_idx_out
// and pal_color_in, combinational, in the same cycle.
//
// Contract
// - Memory map field selects host window at A0000, B0000 or B8000.
// - Compare plane bits choose which planes join colour compare.
// - Write bit mask applies only in write modes 0 and 2, all planes.
// - Mask bit 0 writes latched data; mask bit 1 passes new data.
// - Border colour shown when display enable and blank inactive, except low-res modes other than mode 13.
// - Plane display enable bits gate each plane into pixel stream except 256-colour mode.
// - Status mux routes two colour bits to input status port.
// - Panning value shifts displayed pixels left, mode-limited range.
// - Panning decode differs for nine-dot, mode 13 and other modes.
// - Bank bits may replace colour bits 4 and 5.
// - Bank high bits form colour top bits except 256-colour mode.
// - DAC ports 3C6-3C9 drive DAC strobes, data routed, not stored.
`timescale 1ns/1ns
`default_nettype none
`include "vpa_regs.vh"

module vpa_path (
  input  wire        core_clk_in,     // Core clock, 250 MHz
  input  wire        rstn_in,         // Async reset, active low
  // Host I/O
  input  wire [15:0] io_addr_in,      // I/O port address
  input  wire        io_rd_in,        // I/O read, level
  input  wire        io_wr_in,        // I/O write, level
  input  wire [7:0]  io_wdata_in,     // I/O write data
  output reg  [7:0]  io_rdata_out,    // I/O read data, next clock
  // Host memory write path
  input  wire [19:0] mem_addr_in,     // Host memory address
  output reg         mem_hit_out,     // Address in display window
  input  wire        mem_wr_in,       // Host memory write pulse
  input  wire [31:0] mem_src_in,      // Write data after mode logic
  input  wire [31:0] mem_latch_in,    // Latches from last read
  output reg         mem_wr_out,      // Plane write pulse
  output reg  [31:0] mem_wdata_out,   // Per-plane write data
  output wire [3:0]  cmp_planes_out,  // Planes joining compare
  // Pixel path
  input  wire        nine_dot_in,     // Nine-dot or mono text mode
  input  wire        mode13_in,       // Mode 13 active
  input  wire        low_res_in,      // 40-column or 320-pixel mode
  input  wire        bank_sub_in,     // Use bank bits for colour 5:4
  input  wire [7:0]  pix_in,          // Serialised pixel from memory
  output wire [3:0]  plane_idx_out,   // Panned index to palette
  input  wire [5:0]  pal_color_in,    // Palette output for index
  input  wire        disp_en_in,      // Display enable, high active
  input  wire        blank_in,        // Blanking, high active
  output reg  [7:0]  color_out,       // Colour value to DAC
  output reg  [1:0]  stat_mux_out,    // Status port colour pair
  // External DAC
  output wire        dac_read_strobe_n_out,  // DAC read, low
  output wire        dac_write_strobe_n_out, // DAC write, low
  output wire [1:0]  dac_rs_out,      // DAC register select
  output wire [7:0]  dac_data_out,    // DAC data out
  output wire        dac_data_oe_out, // DAC data drive enable
  input  wire [7:0]  dac_data_in      // DAC data in
);

  // --------------------------------------------------------------
  // Register storage; only defined bits exist
  // --------------------------------------------------------------
  reg [3:0] gc_index_reg;
  reg [1:0] gc_wmode_reg;
  reg       gc_shift_reg;
  reg       gc_256_reg;
  reg [1:0] gc_map_reg;
  reg [3:0] color_compare_plane_select_reg;
  reg [7:0] write_bit_protect_mask_reg;
  reg [4:0] ac_index_reg;
  reg       ac_flip_reg;
  reg [7:0] border_color_value_reg;
  reg [5:0] plane_display_enable_reg;
  reg [3:0] pixel_left_shift_reg;
  reg [3:0] palette_bank_select_reg;

  wire io_gc_idx  = (io_addr_in == `VPA_IO_GC_INDEX);
  wire io_gc_dat  = (io_addr_in == `VPA_IO_GC_DATA);
  wire io_ac_wr   = (io_addr_in == `VPA_IO_ATTR_WR);
  wire io_ac_rd   = (io_addr_in == `VPA_IO_ATTR_RD);
  wire io_stat    = (io_addr_in == `VPA_IO_STAT_COLOR) ||
                    (io_addr_in == `VPA_IO_STAT_MONO);
  wire io_dac     = (io_addr_in >= `VPA_IO_DAC_FIRST) &&
                    (io_addr_in <= `VPA_IO_DAC_LAST);

  // Write and read strobes are edges of the host levels
  reg  io_wr_d_reg;
  reg  io_rd_d_reg;
  wire wr_pulse = io_wr_in && !io_wr_d_reg;
  wire rd_pulse = io_rd_in && !io_rd_d_reg;

  // --------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      io_wr_d_reg                    <= 1'b0;
      io_rd_d_reg                    <= 1'b0;
      gc_index_reg                   <= 4'h0;
      gc_wmode_reg                   <= 2'h0;
      gc_shift_reg                   <= 1'b0;
      gc_256_reg                     <= 1'b0;
      gc_map_reg                     <= 2'h0;
      color_compare_plane_select_reg <= 4'h0;
      write_bit_protect_mask_reg     <= 8'h00;
      ac_index_reg                   <= 5'h00;
      ac_flip_reg                    <= 1'b0;
      border_color_value_reg         <= 8'h00;
      plane_display_enable_reg       <= 6'h00;
      pixel_left_shift_reg           <= 4'h0;
      palette_bank_select_reg        <= 4'h0;
    end else begin
      io_wr_d_reg <= io_wr_in;
      io_rd_d_reg <= io_rd_in;
      if (wr_pulse && io_gc_idx)
        gc_index_reg <= io_wdata_in[3:0];
      if (wr_pulse && io_gc_dat) begin
        case (gc_index_reg)
          `VPA_GC_MODE: begin
            gc_wmode_reg <= io_wdata_in[1:0];
            gc_shift_reg <= io_wdata_in[5];
            gc_256_reg   <= io_wdata_in[6];
          end
          `VPA_GC_MISC:       gc_map_reg <= io_wdata_in[3:2];
          `VPA_GC_CMP_PLANES: color_compare_plane_select_reg <= io_wdata_in[3:0];
          `VPA_GC_BIT_MASK:   write_bit_protect_mask_reg <= io_wdata_in;
          default: ;
        endcase
      end
      // Index/data toggle; a status read puts it back to index
      if (rd_pulse && io_stat) begin
        ac_flip_reg <= 1'b0;
      end else if (wr_pulse && io_ac_wr) begin
        ac_flip_reg <= !ac_flip_reg;
        if (!ac_flip_reg) begin
          ac_index_reg <= io_wdata_in[4:0];
        end else begin
          case (ac_index_reg)
            `VPA_AC_BORDER:   border_color_value_reg   <= io_wdata_in;
            `VPA_AC_PLANE_EN: plane_display_enable_reg <= io_wdata_in[5:0];
            `VPA_AC_PAN:      pixel_left_shift_reg     <= io_wdata_in[3:0];
            `VPA_AC_BANK:     palette_bank_select_reg  <= io_wdata_in[3:0];
            default: ;
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Register reads; DAC reads return pin data, nothing stored
  // --------------------------------------------------------------
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    if (io_gc_idx) begin
      rd_mux = {4'h0, gc_index_reg};
    end else if (io_gc_dat) begin
      case (gc_index_reg)
        `VPA_GC_MODE:       rd_mux = {1'b0, gc_256_reg, gc_shift_reg, 3'h0, gc_wmode_reg};
        `VPA_GC_MISC:       rd_mux = {4'h0, gc_map_reg, 2'h0};
        `VPA_GC_CMP_PLANES: rd_mux = {4'h0, color_compare_plane_select_reg};
        `VPA_GC_BIT_MASK:   rd_mux = write_bit_protect_mask_reg;
        default:            rd_mux = 8'h00;
      endcase
    end else if (io_ac_wr) begin
      rd_mux = {3'h0, ac_index_reg};
    end else if (io_ac_rd) begin
      case (ac_index_reg)
        `VPA_AC_BORDER:   rd_mux = border_color_value_reg;
        `VPA_AC_PLANE_EN: rd_mux = {2'h0, plane_display_enable_reg};
        `VPA_AC_PAN:      rd_mux = {4'h0, pixel_left_shift_reg};
        `VPA_AC_BANK:     rd_mux = {4'h0, palette_bank_select_reg};
        default:          rd_mux = 8'h00;
      endcase
    end else if (io_stat) begin
      rd_mux = {2'h0, stat_mux_out, 4'h0};
    end else if (io_dac) begin
      rd_mux = dac_data_in;
    end
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      io_rdata_out <= 8'h00;
    else if (io_rd_in)
      io_rdata_out <= rd_mux;
  end

  // --------------------------------------------------------------
  // DAC strobes follow the host command directly
  // --------------------------------------------------------------
  assign dac_read_strobe_n_out  = !(io_rd_in && io_dac);
  assign dac_write_strobe_n_out = !(io_wr_in && io_dac);
  wire [15:0] dac_off           = io_addr_in - `VPA_IO_DAC_FIRST;
  assign dac_rs_out             = dac_off[1:0];
  assign dac_data_out           = io_wdata_in;
  assign dac_data_oe_out        = io_wr_in && io_dac;

  // --------------------------------------------------------------
  // Host memory window and write mask
  // --------------------------------------------------------------
  always @* begin
    case (gc_map_reg)
      `VPA_MAP_A0_128K: mem_hit_out = (mem_addr_in[19:17] == `VPA_SEG_A0 >> 2);
      `VPA_MAP_A0_64K:  mem_hit_out = (mem_addr_in[19:16] == `VPA_SEG_A0 >> 1);
      `VPA_MAP_B0_32K:  mem_hit_out = (mem_addr_in[19:15] == `VPA_SEG_B0);
      `VPA_MAP_B8_32K:  mem_hit_out = (mem_addr_in[19:15] == `VPA_SEG_B8);
      default:          mem_hit_out = 1'b0;
    endcase
  end

  assign cmp_planes_out = color_compare_plane_select_reg;

  wire mask_on = (gc_wmode_reg == `VPA_WMODE_0) ||
                 (gc_wmode_reg == `VPA_WMODE_2);
  wire [31:0] mask32 = mask_on ? {4{write_bit_protect_mask_reg}} : 32'hFFFF_FFFF;

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_wr_out    <= 1'b0;
      mem_wdata_out <= 32'h0000_0000;
    end else begin
      mem_wr_out <= mem_wr_in;
      if (mem_wr_in)
        mem_wdata_out <= (mem_src_in & mask32) | (mem_latch_in & ~mask32);
    end
  end

  // --------------------------------------------------------------
  // Pixel path
  // --------------------------------------------------------------
  wire [7:0] pix_gated = gc_256_reg ? pix_in :
                         {4'h0, pix_in[3:0] & plane_display_enable_reg[3:0]};
  wire [7:0] pix_panned;

  vpa_pan u_pan (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .pan_val_in  (pixel_left_shift_reg),
    .nine_dot_in (nine_dot_in),
    .mode13_in   (mode13_in),
    .pix_in      (pix_gated),
    .pix_out     (pix_panned)
  );

  assign plane_idx_out = pix_panned[3:0];

  // Border suppressed in low-resolution modes other than mode 13
  wire border_ok = !low_res_in || mode13_in;
  reg [7:0] color_next;
  always @* begin
    if (gc_256_reg)
      color_next = pix_panned;
    else
      color_next = {palette_bank_select_reg[3:2],
                    bank_sub_in ? palette_bank_select_reg[1:0]
                                : pal_color_in[5:4],
                    pal_color_in[3:0]};
    if (blank_in || !disp_en_in)
      color_next = (!blank_in && border_ok) ? border_color_value_reg : 8'h00;
  end

  reg [1:0] stat_next;
  always @* begin
    case (plane_display_enable_reg[5:4])
      `VPA_MUX_P2P0: stat_next = {color_next[2], color_next[0]};
      `VPA_MUX_P5P4: stat_next = {color_next[5], color_next[4]};
      `VPA_MUX_P3P1: stat_next = {color_next[3], color_next[1]};
      `VPA_MUX_P7P6: stat_next = {color_next[7], color_next[6]};
      default:       stat_next = 2'h0;
    endcase
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      color_out    <= 8'h00;
      stat_mux_out <= 2'h0;
    end else begin
      color_out    <= color_next;
      stat_mux_out <= stat_next;
    end
  end

endmodule
`default_nettype wire

// File: core/vpa_regs.vh
// Register indices, I/O ports, field positions and decode constants
// for the plane, mask and attribute path. Definitions only.
`ifndef VPA_REGS_VH
`define VPA_REGS_VH

// Host I/O port addresses
`define VPA_IO_ATTR_WR     16'h03C0
`define VPA_IO_ATTR_RD     16'h03C1
`define VPA_IO_DAC_FIRST   16'h03C6
`define VPA_IO_DAC_LAST    16'h03C9
`define VPA_IO_GC_INDEX    16'h03CE
`define VPA_IO_GC_DATA     16'h03CF
`define VPA_IO_STAT_COLOR  16'h03DA
`define VPA_IO_STAT_MONO   16'h03BA

// Graphics controller indices
`define VPA_GC_MODE        4'h5
`define VPA_GC_MISC        4'h6
`define VPA_GC_CMP_PLANES  4'h7
`define VPA_GC_BIT_MASK    4'h8

// Attribute controller indices
`define VPA_AC_BORDER      5'h11
`define VPA_AC_PLANE_EN    5'h12
`define VPA_AC_PAN         5'h13
`define VPA_AC_BANK        5'h14

// Write modes, memory window codes
`define VPA_WMODE_0        2'h0
`define VPA_WMODE_2        2'h2
`define VPA_MAP_A0_128K    2'h0
`define VPA_MAP_A0_64K     2'h1
`define VPA_MAP_B0_32K     2'h2
`define VPA_MAP_B8_32K     2'h3

// Host memory address windows (bits 19:15)
`define VPA_SEG_A0         5'h14
`define VPA_SEG_A8         5'h15
`define VPA_SEG_B0         5'h16
`define VPA_SEG_B8         5'h17

// Status mux codes
`define VPA_MUX_P2P0       2'h0
`define VPA_MUX_P5P4       2'h1
`define VPA_MUX_P3P1       2'h2
`define VPA_MUX_P7P6       2'h3

// Panning
`define VPA_PAN_NINE_ZERO  4'h8
`define VPA_PAN_DEPTH      9
`define VPA_PAN_LAST       4'h8

`endif

// File: core/vpa_pan.v
// Horizontal pixel panning: decodes the shift value and picks a tap
// of a fixed nine-stage pixel delay line.
// Assumes one pixel per core clock; latency is 10 clocks minus the decoded shift.
`timescale 1ns/1ns
`default_nettype none
`include "vpa_regs.vh"

module vpa_pan (
  input  wire       core_clk_in,  // Core clock
  input  wire       rstn_in,      // Async reset, active low
  input  wire [3:0] pan_val_in,   // Stored panning value
  input  wire       nine_dot_in,  // Nine-dot or mono text mode
  input  wire       mode13_in,    // 256-colour mode 13
  input  wire [7:0] pix_in,       // Pixel stream in
  output reg  [7:0] pix_out       // Panned pixel stream
);

  // --------------------------------------------------------------
  // Shift decode
  // --------------------------------------------------------------
  reg [3:0] shift;
  always @* begin
    if (mode13_in) begin
      shift = {2'h0, pan_val_in[2:1]};
    end else if (nine_dot_in) begin
      if (pan_val_in < `VPA_PAN_NINE_ZERO)
        shift = pan_val_in + 4'h1;
      else
        shift = 4'h0;
    end else begin
      // Values above seven are undefined here; treat as no shift
      shift = pan_val_in[3] ? 4'h0 : pan_val_in;
    end
  end

  // --------------------------------------------------------------
  // Delay line; older tap means less shift
  // --------------------------------------------------------------
  reg [7:0] line_reg [0:`VPA_PAN_DEPTH-1];
  genvar g;
  generate
    for (g = 0; g < `VPA_PAN_DEPTH; g = g + 1) begin : g_line
      wire [7:0] stage_in;
      if (g == 0) begin : g_head
        assign stage_in = pix_in;
      end else begin : g_tail
        assign stage_in = line_reg[g-1];
      end
      always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
          line_reg[g] <= 8'h00;
        else
          line_reg[g] <= stage_in;
      end
    end
  endgenerate

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      pix_out <= 8'h00;
    else
      pix_out <= line_reg[`VPA_PAN_LAST - shift];
  end

endmodule
`default_nettype wire

// File: verif/vpa_path_monitor.sv
// Checker on the ports of vpa_path: DAC strobes, read path, write pulse.
// Assumes host inputs change just after core_clk_in rises.
`timescale 1ns/1ns
`default_nettype none
`include "vpa_regs.vh"
module vpa_path_monitor (
  input wire logic        core_clk_in,            // Clock
  input wire logic        rstn_in,                // Reset, low
  input wire logic [15:0] io_addr_in,             // Port address
  input wire logic        io_rd_in,               // Read level
  input wire logic        io_wr_in,               // Write level
  input wire logic [7:0]  io_wdata_in,            // Write data
  input wire logic [7:0]  io_rdata_out,           // Read data
  input wire logic        mem_wr_in,              // Write request
  input wire logic        mem_wr_out,             // Plane write
  input wire logic        blank_in,               // Blanking
  input wire logic [7:0]  color_out,              // Colour
  input wire logic        dac_read_strobe_n_out,  // DAC read
  input wire logic        dac_write_strobe_n_out, // DAC write
  input wire logic [1:0]  dac_rs_out,             // DAC select
  input wire logic [7:0]  dac_data_out,           // DAC data
  input wire logic        dac_data_oe_out,        // DAC drive
  input wire logic [7:0]  dac_data_in             // DAC return
);
  wire        dac_sel = (io_addr_in >= `VPA_IO_DAC_FIRST) && (io_addr_in <= `VPA_IO_DAC_LAST);
  wire [15:0] rs_full = io_addr_in - `VPA_IO_DAC_FIRST;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_dac_rd; io_rd_in && dac_sel; endsequence
  sequence s_dac_wr; io_wr_in && dac_sel; endsequence
  property p_dac_rd; dac_read_strobe_n_out == !(io_rd_in && dac_sel); endproperty
  a_dac_rd: assert property (p_dac_rd) else $error("dac read strobe wrong");
  property p_dac_wr; dac_write_strobe_n_out == !(io_wr_in && dac_sel); endproperty
  a_dac_wr: assert property (p_dac_wr) else $error("dac write strobe wrong");
  property p_dac_rs; (io_rd_in || io_wr_in) && dac_sel |-> dac_rs_out == rs_full[1:0]; endproperty
  a_dac_rs: assert property (p_dac_rs) else $error("dac select wrong");
  property p_dac_wdata; s_dac_wr |-> dac_data_oe_out && dac_data_out == io_wdata_in; endproperty
  a_dac_wdata: assert property (p_dac_wdata) else $error("dac write data wrong");
  property p_dac_oe; !(io_wr_in && dac_sel) |-> !dac_data_oe_out; endproperty
  a_dac_oe: assert property (p_dac_oe) else $error("dac bus driven idle");
  property p_dac_rdata; s_dac_rd |=> io_rdata_out == $past(dac_data_in); endproperty
  a_dac_rdata: assert property (p_dac_rdata) else $error("dac read data wrong");
  property p_mem_go; mem_wr_in |=> mem_wr_out; endproperty
  a_mem_go: assert property (p_mem_go) else $error("plane write missing");
  property p_mem_quiet; !mem_wr_in |=> !mem_wr_out; endproperty
  a_mem_quiet: assert property (p_mem_quiet) else $error("plane write spurious");
  property p_blank; blank_in |=> color_out == 8'h00; endproperty
  a_blank: assert property (p_blank) else $error("colour during blank");
endmodule
bind vpa_path vpa_path_monitor vpa_path_monitor_inst (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .io_addr_in(io_addr_in),
  .io_rd_in(io_rd_in), .io_wr_in(io_wr_in), .io_wdata_in(io_wdata_in),
  .io_rdata_out(io_rdata_out), .mem_wr_in(mem_wr_in), .mem_wr_out(mem_wr_out),
  .blank_in(blank_in), .color_out(color_out),
  .dac_read_strobe_n_out(dac_read_strobe_n_out),
  .dac_write_strobe_n_out(dac_write_strobe_n_out), .dac_rs_out(dac_rs_out),
  .dac_data_out(dac_data_out), .dac_data_oe_out(dac_data_oe_out), .dac_data_in(dac_data_in));
`default_nettype wire

// File: verif/vpa_dac_model.sv
// Video DAC stand-in with four byte registers, plus the palette lookup.
// Assumes strobes are low levels held across a clock edge.
`timescale 1ns/1ns
`default_nettype none
module vpa_dac_model (
  input  wire logic       core_clk_in, // Clock
  input  wire logic       rd_n_in,     // Read strobe, low
  input  wire logic       wr_n_in,     // Write strobe, low
  input  wire logic [1:0] rs_in,       // Register select
  input  wire logic [7:0] data_in,     // Data from controller
  output var  logic [7:0] data_out,    // Data to controller
  input  wire logic [3:0] idx_in,      // Palette index
  output var  logic [5:0] pal_out      // Palette colour
);
  logic [7:0] regs [0:3];
  logic [7:0] last_reg = 8'h00;
  // Released bus shows the inverse so a stale byte never matches
  assign data_out = !rd_n_in ? regs[rs_in] : ~last_reg;
  assign pal_out  = {idx_in[1:0], idx_in};
  always @(posedge core_clk_in) begin
    if (!wr_n_in) regs[rs_in] <= data_in;
    if (!rd_n_in) last_reg <= regs[rs_in];
  end
endmodule
`default_nettype wire

// File: verif/vpa_path_tb.sv
// Self-checking bench for vpa_path: registers, masks, map, DAC, colour, panning.
// Assumes the DAC model supplies palette colours in the same cycle.
`timescale 1ns/1ns
`default_nettype none
`include "vpa_regs.vh"
module vpa_path_tb;
  logic        core_clk_in = 1'b0, rstn_in = 1'b0, io_rd_in = 1'b0, io_wr_in = 1'b0;
  logic        mem_wr_in = 1'b0, nine_dot_in = 1'b0, mode13_in = 1'b0, low_res_in = 1'b0;
  logic        bank_sub_in = 1'b0, disp_en_in = 1'b1, blank_in = 1'b0;
  logic [15:0] io_addr_in = 16'h0000;
  logic [19:0] mem_addr_in = 20'h0_0000;
  logic [7:0]  io_wdata_in = 8'h00, pix_in = 8'h00, io_rdata_out, color_out, dac_data_out;
  logic [7:0]  dac_data_in;
  logic [31:0] mem_src_in = 32'h0000_0000, mem_latch_in = 32'h0000_0000, mem_wdata_out;
  logic [3:0]  cmp_planes_out, plane_idx_out;
  logic [5:0]  pal_color_in;
  logic [1:0]  stat_mux_out, dac_rs_out;
  logic        mem_hit_out, mem_wr_out, dac_read_strobe_n_out, dac_write_strobe_n_out;
  logic        dac_data_oe_out;
  integer      err_total = 0, tests_run = 0, cyc = 0;
  always #2 core_clk_in = ~core_clk_in;
  vpa_path vpa_path_inst (.core_clk_in, .rstn_in, .io_addr_in, .io_rd_in, .io_wr_in,
    .io_wdata_in, .io_rdata_out, .mem_addr_in, .mem_hit_out, .mem_wr_in, .mem_src_in,
    .mem_latch_in, .mem_wr_out, .mem_wdata_out, .cmp_planes_out, .nine_dot_in, .mode13_in,
    .low_res_in, .bank_sub_in, .pix_in, .plane_idx_out, .pal_color_in, .disp_en_in,
    .blank_in, .color_out, .stat_mux_out, .dac_read_strobe_n_out, .dac_write_strobe_n_out,
    .dac_rs_out, .dac_data_out, .dac_data_oe_out, .dac_data_in);
  vpa_dac_model vpa_dac_model_inst (.core_clk_in, .rd_n_in(dac_read_strobe_n_out),
    .wr_n_in(dac_write_strobe_n_out), .rs_in(dac_rs_out), .data_in(dac_data_out),
    .data_out(dac_data_in), .idx_in(plane_idx_out), .pal_out(pal_color_in));
  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (exp !== got) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    io_addr_in <= a;
    io_wdata_in <= d;
    io_wr_in <= 1'b1;
    @(posedge core_clk_in);
    io_wr_in <= 1'b0;
  endtask
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    io_addr_in <= a;
    io_rd_in <= 1'b1;
    @(posedge core_clk_in);
    #1 d = io_rdata_out;
    @(posedge core_clk_in);
    io_rd_in <= 1'b0;
  endtask
  task automatic gc_wr(input logic [3:0] i, input logic [7:0] d);
    io_wr(`VPA_IO_GC_INDEX, {4'h0, i});
    io_wr(`VPA_IO_GC_DATA, d);
  endtask
  task automatic gc_rd(input logic [3:0] i, output logic [7:0] d);
    io_wr(`VPA_IO_GC_INDEX, {4'h0, i});
    io_rd(`VPA_IO_GC_DATA, d);
  endtask
  task automatic ac_wr(input logic [4:0] i, input logic [7:0] d);
    logic [7:0] t;
    io_rd(`VPA_IO_STAT_COLOR, t);
    io_wr(`VPA_IO_ATTR_WR, {3'b000, i});
    io_wr(`VPA_IO_ATTR_WR, d);
  endtask
  task automatic ac_rd(input logic [4:0] i, output logic [7:0] d);
    logic [7:0] t;
    io_rd(`VPA_IO_STAT_COLOR, t);
    io_wr(`VPA_IO_ATTR_WR, {3'b000, i});
    io_rd(`VPA_IO_ATTR_RD, d);
  endtask
  task automatic settle;
    repeat (16) @(posedge core_clk_in);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [7:0] d;
    gc_wr(`VPA_GC_CMP_PLANES, 8'hFF);
    gc_rd(`VPA_GC_CMP_PLANES, d);
    chk("cmp planes", 8'h0F, d);
    chk("cmp out", 4'hF, cmp_planes_out);
    gc_wr(`VPA_GC_CMP_PLANES, 8'h05);
    #1 chk("cmp out", 4'h5, cmp_planes_out);
    gc_wr(`VPA_GC_BIT_MASK, 8'hA5);
    gc_rd(`VPA_GC_BIT_MASK, d);
    chk("bit mask", 8'hA5, d);
    gc_wr(4'h9, 8'hFF);
    gc_rd(4'h9, d);
    chk("unmapped index", 8'h00, d);
    ac_wr(`VPA_AC_BORDER, 8'hC3);
    ac_rd(`VPA_AC_BORDER, d);
    chk("border", 8'hC3, d);
    ac_wr(`VPA_AC_PLANE_EN, 8'hFF);
    ac_rd(`VPA_AC_PLANE_EN, d);
    chk("plane enable", 8'h3F, d);
    ac_wr(`VPA_AC_PAN, 8'hFF);
    ac_rd(`VPA_AC_PAN, d);
    chk("pan", 8'h0F, d);
    ac_wr(`VPA_AC_BANK, 8'hFF);
    ac_rd(`VPA_AC_BANK, d);
    chk("bank", 8'h0F, d);
  endtask
  task automatic t_mask;
    integer i;
    gc_wr(`VPA_GC_BIT_MASK, 8'h0F);
    for (i = 0; i < 4; i++) begin
      gc_wr(`VPA_GC_MODE, i[7:0]);
      mem_src_in <= 32'hFFFF_FFFF;
      mem_latch_in <= 32'hA0A0_A0A0;
      mem_wr_in <= 1'b1;
      @(posedge core_clk_in);
      mem_wr_in <= 1'b0;
      #1 chk("plane write", 1'b1, mem_wr_out);
      chk("plane data", (i == 1 || i == 3) ? 32'hFFFF_FFFF : 32'hAFAF_AFAF, mem_wdata_out);
    end
  endtask
  task automatic t_map;
    integer i, j;
    for (i = 0; i < 4; i++) begin
      gc_wr(`VPA_GC_MISC, {4'h0, i[1:0], 2'b00});
      for (j = 0; j < 4; j++) begin
        @(posedge core_clk_in);
        mem_addr_in <= {`VPA_SEG_A0 + j[4:0], 15'h0000};
        @(posedge core_clk_in);
        #1 chk("window hit", 16'h843F >> (i * 4 + j) & 1, mem_hit_out);
      end
    end
  endtask
  task automatic t_dac;
    integer k;
    logic [7:0] d;
    for (k = 0; k < 4; k++) io_wr(`VPA_IO_DAC_FIRST + k[15:0], 8'h30 + k[7:0]);
    for (k = 0; k < 4; k++) begin
      io_rd(`VPA_IO_DAC_FIRST + k[15:0], d);
      chk("dac reg", 8'h30 + k[7:0], d);
    end
  endtask
  task automatic t_color;
    ac_wr(`VPA_AC_PLANE_EN, 8'h0F);
    ac_wr(`VPA_AC_PAN, 8'h00);
    ac_wr(`VPA_AC_BANK, 8'h0D);
    ac_wr(`VPA_AC_BORDER, 8'h5A);
    pix_in <= 8'h06;
    settle;
    chk("colour", 8'hE6, color_out);
    @(posedge core_clk_in);
    bank_sub_in <= 1'b1;
    settle;
    chk("bank colour", 8'hD6, color_out);
    ac_wr(`VPA_AC_PLANE_EN, 8'h02);
    settle;
    chk("plane gate", 8'hD2, color_out);
    @(posedge core_clk_in);
    disp_en_in <= 1'b0;
    settle;
    chk("border", 8'h5A, color_out);
    @(posedge core_clk_in);
    blank_in <= 1'b1;
    settle;
    chk("blank", 8'h00, color_out);
    @(posedge core_clk_in);
    blank_in <= 1'b0;
    low_res_in <= 1'b1;
    settle;
    chk("low res border", 8'h00, color_out);
    @(posedge core_clk_in);
    mode13_in <= 1'b1;
    settle;
    chk("mode 13 border", 8'h5A, color_out);
    @(posedge core_clk_in);
    disp_en_in <= 1'b1;
    low_res_in <= 1'b0;
    pix_in <= 8'hA5;
  endtask
  task automatic t_status;
    integer i;
    logic [7:0] d;
    gc_wr(`VPA_GC_MODE, 8'h40);
    for (i = 0; i < 4; i++) begin
      ac_wr(`VPA_AC_PLANE_EN, {2'b00, i[1:0], 4'hF});
      settle;
      chk("attribute colour", 8'hA5, color_out);
      chk("status pair", 8'h8B >> (i * 2) & 3, stat_mux_out);
      io_rd(`VPA_IO_STAT_COLOR, d);
      chk("status port", (8'h8B >> (i * 2) & 3) << 4, d);
    end
  endtask
  task automatic pan_case(input logic nine, input logic m13, input logic [3:0] v,
                          input logic [3:0] s);
    integer n;
    ac_wr(`VPA_AC_PAN, {4'h0, v});
    nine_dot_in <= nine;
    mode13_in <= m13;
    pix_in <= 8'h00;
    settle;
    @(posedge core_clk_in);
    pix_in <= 8'h05;
    n = 0;
    while (plane_idx_out !== 4'h5 && n < 12) begin
      @(posedge core_clk_in);
      #1 n++;
    end
    chk("pan delay", 10 - s, n);
  endtask
  task automatic print_verdict;
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Generous ceiling: the whole sequence needs under a thousand clocks
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    repeat (6) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    t_regs;
    t_mask;
    t_map;
    t_dac;
    t_color;
    t_status;
    pan_case(1'b0, 1'b0, 4'h3, 4'h3);
    pan_case(1'b0, 1'b0, 4'h7, 4'h7);
    pan_case(1'b0, 1'b0, 4'h9, 4'h0);
    pan_case(1'b1, 1'b0, 4'h0, 4'h1);
    pan_case(1'b1, 1'b0, 4'h7, 4'h8);
    pan_case(1'b1, 1'b0, 4'h8, 4'h0);
    pan_case(1'b0, 1'b1, 4'h6, 4'h3);
    pan_case(1'b0, 1'b1, 4'h2, 4'h1);
    print_verdict;
  end
endmodule
`default_nettype wire
